// ---- core/i2c_bus_timing.sv ----
// Two-wire master bus timing generator with idle detect and an AXI4-Lite register slave.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_timing #(
  parameter logic [i2c_timing_pkg::TW-1:0] IDLE_CYC = i2c_timing_pkg::CYC_IDLE
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [i2c_timing_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  input wire logic [i2c_timing_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  input wire logic serialClockIn,
  output var logic serialClockOut,
  output var logic serialClockOeN,
  input wire logic serialDataLineIn,
  output var logic serialDataLineOut,
  output var logic serialDataLineOeN,
  output var logic irq
);
  import i2c_timing_pkg::*;

  localparam logic [31:0] TIM_RST [NUM_TIM] = '{
    {CYC_HD_STA, CYC_SU_STA}, {IDLE_CYC, CYC_SU_STO}, {CYC_HD_DAT, CYC_SU_DAT},
    {CYC_HIGH_NOM, CYC_LOW_NOM}, {CYC_HIGH_MIN, CYC_LOW_MIN}};

  state_t stateFf, nxt_state;
  op_t opFf, nxt_op;
  logic [2:0] sclSyncFf, nxt_sclSync, sdaSyncFf, nxt_sdaSync;
  logic bitFf, nxt_bit, rxBitFf, nxt_rxBit, pendFf, nxt_pend;
  logic nxt_sclOeN, nxt_sdaOeN;
  logic [31:0] workFf [NUM_TIM];
  logic [31:0] nxt_work [NUM_TIM];
  logic [NUM_TMR-1:0] tmrClr;
  logic [TW-1:0] tmrCnt [NUM_TMR];
  logic [EV_W-1:0] evSet;

  logic [ADDR_W-1:0] awAddrFf, nxt_awAddr;
  logic awHeldFf, nxt_awHeld, wHeldFf, nxt_wHeld;
  logic [31:0] wDataFf, nxt_wData;
  logic [3:0] wStrbFf, nxt_wStrb;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid, nxt_irq;
  logic [1:0] nxt_bresp, nxt_rresp;
  logic [31:0] nxt_rdata;
  logic [31:0] timRegFf [NUM_TIM];
  logic [31:0] nxt_timReg [NUM_TIM];
  logic [EV_W-1:0] intStatFf, nxt_intStat, intMaskFf, nxt_intMask;
  logic wrFire, cmdChain, srst;
  op_t cmdOp;
  logic cmdBit;

  logic sclS, sclD, sdaS, sdaD, sclRise, sclFall, sdaRise, sdaFall;
  logic [TW-1:0] staSu, staHd, stoSu, idleCyc, datSu, datHd, hiNom, loNom, hiMin, loMin;

  assign sclS = sclSyncFf[1];
  assign sclD = sclSyncFf[2];
  assign sdaS = sdaSyncFf[1];
  assign sdaD = sdaSyncFf[2];
  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;
  assign sdaRise = sdaS && !sdaD;
  assign sdaFall = !sdaS && sdaD;

  // The machine reads only the working copy, never the software registers.
  assign staSu = workFf[TI_START][FLD_LO +: TW];
  assign staHd = workFf[TI_START][FLD_HI +: TW];
  assign stoSu = workFf[TI_STOPIDLE][FLD_LO +: TW];
  assign idleCyc = workFf[TI_STOPIDLE][FLD_HI +: TW];
  assign datSu = workFf[TI_DATA][FLD_LO +: TW];
  assign datHd = workFf[TI_DATA][FLD_HI +: TW];
  assign loNom = workFf[TI_NOM][FLD_LO +: TW];
  assign hiNom = workFf[TI_NOM][FLD_HI +: TW];
  assign loMin = workFf[TI_MIN][FLD_LO +: TW];
  assign hiMin = workFf[TI_MIN][FLD_HI +: TW];

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newV[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  for (genvar t = 0; t < NUM_TMR; t++) begin : gTmr
    i2c_timer #(.W(TW)) uTmr (
      .sys_clk(sys_clk),
      .reset(reset),
      .clkEn(clkEn),
      .clr(tmrClr[t]),
      .count(tmrCnt[t])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register slave. Address and data are caught in either order; the write
  // happens one cycle after both are held.

  always_comb begin
    logic [31:0] merged;
    logic hit;
    merged = '0;
    hit = 1'b0;
    nxt_awAddr = awAddrFf;
    nxt_awHeld = awHeldFf;
    nxt_wData = wDataFf;
    nxt_wStrb = wStrbFf;
    nxt_wHeld = wHeldFf;
    nxt_bvalid = bvalid;
    nxt_bresp = bresp;
    nxt_rvalid = rvalid;
    nxt_rdata = rdata;
    nxt_rresp = rresp;
    nxt_timReg = timRegFf;
    nxt_intMask = intMaskFf;
    nxt_intStat = intStatFf;
    cmdOp = OP_NONE;
    cmdBit = 1'b0;
    cmdChain = 1'b0;
    srst = 1'b0;
    wrFire = awHeldFf && wHeldFf && !bvalid;
    if (awvalid && awready) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_wHeld = 1'b1;
      nxt_wData = wdata;
      nxt_wStrb = wstrb;
    end
    if (bvalid && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wrFire) begin
      merged = mergeBytes('0, wDataFf, wStrbFf);
      hit = 1'b1;
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bvalid = 1'b1;
      unique case (awAddrFf)
        OFS_CMD: begin
          cmdOp = op_t'(merged[CMD_OP_LSB +: 2]);
          cmdBit = merged[CMD_DATA_BIT];
          cmdChain = merged[CMD_CHAIN_BIT];
        end
        OFS_SRST: srst = merged[SRST_BIT];
        OFS_STATUS: hit = 1'b1;
        OFS_INT_STAT: nxt_intStat = intStatFf & ~merged[EV_W-1:0];
        OFS_INT_MASK: nxt_intMask = wStrbFf[0] ? merged[EV_W-1:0] : intMaskFf;
        default: begin
          hit = 1'b0;
          for (int i = 0; i < NUM_TIM; i++) begin
            if (awAddrFf == OFS_TIM0 + ADDR_W'(i) * TIM_STRIDE) begin
              nxt_timReg[i] = mergeBytes(timRegFf[i], wDataFf, wStrbFf);
              hit = 1'b1;
            end
          end
        end
      endcase
      nxt_bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    // A hardware event in the same cycle as its clear still sets the bit.
    nxt_intStat = nxt_intStat | evSet;
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      unique case (araddr)
        OFS_CMD, OFS_SRST: nxt_rdata = '0;
        OFS_STATUS: begin
          nxt_rdata[ST_BUSY] = !(stateFf inside {S_POWERUP, S_WAIT_IDLE, S_IDLE});
          nxt_rdata[ST_IDLE] = stateFf == S_IDLE;
          nxt_rdata[ST_READY] = stateFf == S_LOW_WAIT;
          nxt_rdata[ST_RXBIT] = rxBitFf;
          nxt_rdata[ST_SCL] = sclS;
          nxt_rdata[ST_SDA] = sdaS;
        end
        OFS_INT_STAT: nxt_rdata[EV_W-1:0] = intStatFf;
        OFS_INT_MASK: nxt_rdata[EV_W-1:0] = intMaskFf;
        default: begin
          nxt_rresp = RESP_SLVERR;
          for (int i = 0; i < NUM_TIM; i++) begin
            if (araddr == OFS_TIM0 + ADDR_W'(i) * TIM_STRIDE) begin
              nxt_rdata = timRegFf[i];
              nxt_rresp = RESP_OKAY;
            end
          end
        end
      endcase
    end else if (rvalid && rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_awready = !nxt_awHeld;
    nxt_wready = !nxt_wHeld;
    nxt_arready = !nxt_rvalid;
    nxt_irq = |(nxt_intStat & nxt_intMask);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      awAddrFf <= '0;
      awHeldFf <= 1'b0;
      wDataFf <= '0;
      wStrbFf <= '0;
      wHeldFf <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      for (int i = 0; i < NUM_TIM; i++) begin
        timRegFf[i] <= TIM_RST[i];
      end
      intStatFf <= '0;
      intMaskFf <= '0;
      irq <= 1'b0;
    end else if (clkEn) begin
      awAddrFf <= nxt_awAddr;
      awHeldFf <= nxt_awHeld;
      wDataFf <= nxt_wData;
      wStrbFf <= nxt_wStrb;
      wHeldFf <= nxt_wHeld;
      awready <= nxt_awready;
      wready <= nxt_wready;
      bvalid <= nxt_bvalid;
      bresp <= nxt_bresp;
      arready <= nxt_arready;
      rvalid <= nxt_rvalid;
      rdata <= nxt_rdata;
      rresp <= nxt_rresp;
      timRegFf <= nxt_timReg;
      intStatFf <= nxt_intStat;
      intMaskFf <= nxt_intMask;
      irq <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus timing machine. The pins are open drain: an enable low pulls the line.
  // Every timer compare is count >= setting; a setting of zero passes at once.

  always_comb begin
    nxt_sclSync = {sclSyncFf[1:0], serialClockIn};
    nxt_sdaSync = {sdaSyncFf[1:0], serialDataLineIn};
    nxt_state = stateFf;
    nxt_op = opFf;
    nxt_bit = bitFf;
    nxt_rxBit = rxBitFf;
    nxt_pend = pendFf;
    nxt_sclOeN = serialClockOeN;
    nxt_sdaOeN = serialDataLineOeN;
    nxt_work = workFf;
    tmrClr = '0;
    evSet = '0;
    tmrClr[T_EDGE] = sclRise || sclFall;
    if (cmdChain) begin
      nxt_work = timRegFf;
    end
    if (cmdOp == OP_START && stateFf inside {S_POWERUP, S_WAIT_IDLE, S_IDLE}) begin
      nxt_pend = 1'b1;
    end
    unique case (stateFf)
      S_POWERUP: begin
        if (!sclS) begin
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (tmrCnt[T_PH] >= idleCyc) begin
          nxt_state = S_IDLE;
          evSet[EV_IDLE] = 1'b1;
        end
      end
      S_WAIT_IDLE: begin
        if (!(sclS && sdaS)) begin
          tmrClr[T_PH] = 1'b1;
        end else if (sdaRise) begin
          nxt_state = S_IDLE;
          evSet[EV_IDLE] = 1'b1;
        end else if (tmrCnt[T_PH] >= idleCyc) begin
          nxt_state = S_IDLE;
          evSet[EV_IDLE] = 1'b1;
        end
      end
      S_IDLE: begin
        if (sclS && sdaFall) begin
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (pendFf || cmdOp == OP_START) begin
          nxt_pend = 1'b0;
          nxt_work = timRegFf;
          nxt_state = S_STA_SETUP;
          tmrClr[T_PH] = 1'b1;
        end
      end
      S_STA_SETUP: begin
        if (!sclS || !sdaS) begin
          evSet[EV_COL] = 1'b1;
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (tmrCnt[T_PH] >= staSu) begin
          nxt_sdaOeN = 1'b0;
          nxt_state = S_STA_HOLD;
          tmrClr[T_PH] = 1'b1;
        end
      end
      S_STA_HOLD: begin
        if (!sclS) begin
          evSet[EV_COL] = 1'b1;
          nxt_sdaOeN = 1'b1;
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (sdaS) begin
          tmrClr[T_PH] = 1'b1;
        end else if (tmrCnt[T_PH] >= staHd) begin
          nxt_sclOeN = 1'b0;
          tmrClr[T_NOM] = 1'b1;
          nxt_state = S_LOW_WAIT;
          evSet[EV_DONE] = 1'b1;
        end
      end
      S_LOW_WAIT: begin
        if (cmdOp != OP_NONE) begin
          nxt_op = cmdOp;
          nxt_bit = cmdBit;
          nxt_state = S_LOW_HOLD;
        end
      end
      S_LOW_HOLD: begin
        // A foreign pull on the data line here is not an error.
        if (tmrCnt[T_EDGE] >= datHd) begin
          nxt_sdaOeN = (opFf == OP_STOP) ? 1'b0 : (opFf == OP_START) ? 1'b1 : bitFf;
          nxt_state = S_LOW_SETUP;
          tmrClr[T_PH] = 1'b1;
        end
      end
      S_LOW_SETUP: begin
        // The data line is not read back here, so a foreign pull on it goes unseen;
        // it shows up later as a lost bit or collision.
        if (tmrCnt[T_PH] >= datSu && tmrCnt[T_EDGE] >= loMin && tmrCnt[T_NOM] >= loNom) begin
          nxt_sclOeN = 1'b1;
          tmrClr[T_NOM] = 1'b1;
          nxt_state = S_RISE;
        end
      end
      S_RISE: begin
        if (sclS) begin
          nxt_rxBit = sdaS;
          tmrClr[T_PH] = 1'b1;
          unique case (opFf)
            OP_STOP: nxt_state = S_STO_SETUP;
            OP_START: nxt_state = S_STA_SETUP;
            default: nxt_state = S_HIGH;
          endcase
        end
      end
      S_HIGH: begin
        if (sclFall) begin
          nxt_sclOeN = 1'b0;
          tmrClr[T_NOM] = 1'b1;
          nxt_state = S_LOW_WAIT;
          evSet[EV_DONE] = 1'b1;
        end else if (bitFf && !sdaS) begin
          evSet[EV_ARB] = 1'b1;
          nxt_sdaOeN = 1'b1;
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (tmrCnt[T_EDGE] >= hiMin && tmrCnt[T_NOM] >= hiNom) begin
          nxt_sclOeN = 1'b0;
          tmrClr[T_NOM] = 1'b1;
          nxt_rxBit = sdaS;
          nxt_state = S_LOW_WAIT;
          evSet[EV_DONE] = 1'b1;
        end
      end
      S_STO_SETUP: begin
        if (!sclS) begin
          evSet[EV_COL] = 1'b1;
          nxt_sdaOeN = 1'b1;
          nxt_state = S_WAIT_IDLE;
          tmrClr[T_PH] = 1'b1;
        end else if (tmrCnt[T_EDGE] >= stoSu) begin
          nxt_sdaOeN = 1'b1;
          nxt_state = S_IDLE;
          evSet[EV_DONE] = 1'b1;
        end
      end
      default: nxt_state = S_POWERUP;
    endcase
    if (srst) begin
      nxt_state = S_POWERUP;
      nxt_work = timRegFf;
      nxt_sclOeN = 1'b1;
      nxt_sdaOeN = 1'b1;
      nxt_pend = 1'b0;
      tmrClr[T_PH] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stateFf <= S_POWERUP;
      opFf <= OP_NONE;
      bitFf <= 1'b1;
      rxBitFf <= 1'b0;
      pendFf <= 1'b0;
      sclSyncFf <= 3'h7;
      sdaSyncFf <= 3'h7;
      serialClockOeN <= 1'b1;
      serialDataLineOeN <= 1'b1;
      serialClockOut <= 1'b0;
      serialDataLineOut <= 1'b0;
      for (int i = 0; i < NUM_TIM; i++) begin
        workFf[i] <= TIM_RST[i];
      end
    end else if (clkEn) begin
      stateFf <= nxt_state;
      opFf <= nxt_op;
      bitFf <= nxt_bit;
      rxBitFf <= nxt_rxBit;
      pendFf <= nxt_pend;
      sclSyncFf <= nxt_sclSync;
      sdaSyncFf <= nxt_sdaSync;
      serialClockOeN <= nxt_sclOeN;
      serialDataLineOeN <= nxt_sdaOeN;
      serialClockOut <= 1'b0;
      serialDataLineOut <= 1'b0;
      workFf <= nxt_work;
    end
  end

endmodule : i2c_bus_timing
`default_nettype wire

// ---- core/i2c_timer.sv ----
// Free-running saturating cycle counter used for every bus timing interval.
`timescale 1ns/10ps
`default_nettype none
module i2c_timer #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic clr,
  output var logic [W-1:0] count
);

  logic [W-1:0] nxt_count;

  always_comb begin
    nxt_count = count;
    if (clr) begin
      nxt_count = '0;
    end else if (count != '1) begin
      nxt_count = count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clkEn) begin
      count <= nxt_count;
    end
  end

endmodule : i2c_timer
`default_nettype wire

// ---- core/i2c_timing_pkg.sv ----
// Register map, timing defaults and state codes of the two-wire bus timing block.
package i2c_timing_pkg;

  localparam int CLK_MHZ = 125;
  localparam int TW = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_TIM = 5;
  localparam int NUM_TMR = 3;
  localparam int EV_W = 4;

  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SRST = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TIM0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h24;
  localparam logic [ADDR_W-1:0] TIM_STRIDE = 8'h04;

  // Timing words, in order from OFS_TIM0; low half and high half of each.
  localparam int TI_START = 0;
  localparam int TI_STOPIDLE = 1;
  localparam int TI_DATA = 2;
  localparam int TI_NOM = 3;
  localparam int TI_MIN = 4;
  localparam int FLD_LO = 0;
  localparam int FLD_HI = 16;

  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_BIT = 4;
  localparam int CMD_CHAIN_BIT = 8;
  localparam int SRST_BIT = 0;

  localparam int ST_BUSY = 0;
  localparam int ST_IDLE = 1;
  localparam int ST_READY = 2;
  localparam int ST_RXBIT = 3;
  localparam int ST_SCL = 4;
  localparam int ST_SDA = 5;

  localparam int EV_DONE = 0;
  localparam int EV_COL = 1;
  localparam int EV_ARB = 2;
  localparam int EV_IDLE = 3;

  localparam int T_EDGE = 0;
  localparam int T_NOM = 1;
  localparam int T_PH = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Standard-mode figures in nanoseconds.
  localparam int T_SU_STA_NS = 4700;
  localparam int T_HD_STA_NS = 4000;
  localparam int T_SU_STO_NS = 4000;
  localparam int T_SU_DAT_NS = 250;
  localparam int T_HD_DAT_NS = 300;
  localparam int T_HIGH_NOM_NS = 5000;
  localparam int T_LOW_NOM_NS = 5000;
  localparam int T_HIGH_MIN_NS = 4000;
  localparam int T_LOW_MIN_NS = 4700;
  localparam int T_IDLE_NS = 50000;

  localparam logic [TW-1:0] CYC_SU_STA = TW'((T_SU_STA_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_HD_STA = TW'((T_HD_STA_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_SU_STO = TW'((T_SU_STO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_SU_DAT = TW'((T_SU_DAT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_HD_DAT = TW'((T_HD_DAT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_HIGH_NOM = TW'((T_HIGH_NOM_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_LOW_NOM = TW'((T_LOW_NOM_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_HIGH_MIN = TW'((T_HIGH_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_LOW_MIN = TW'((T_LOW_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TW-1:0] CYC_IDLE = TW'((T_IDLE_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_START = 2'h1,
    OP_BIT = 2'h2,
    OP_STOP = 2'h3
  } op_t;

  typedef enum logic [3:0] {
    S_POWERUP = 4'h0,
    S_WAIT_IDLE = 4'h1,
    S_IDLE = 4'h2,
    S_STA_SETUP = 4'h3,
    S_STA_HOLD = 4'h4,
    S_LOW_WAIT = 4'h5,
    S_LOW_HOLD = 4'h6,
    S_LOW_SETUP = 4'h7,
    S_RISE = 4'h8,
    S_HIGH = 4'h9,
    S_STO_SETUP = 4'ha
  } state_t;

endpackage : i2c_timing_pkg

// ---- sim/i2c_bus_timing_checker.sv ----
// Timing assertions on the two-wire bus pins of the bus timing block.
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_timing_checker #(
  parameter logic [i2c_timing_pkg::TW-1:0] IDLE_CYC = i2c_timing_pkg::CYC_IDLE
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic serialClockIn,
  input wire logic serialClockOeN,
  input wire logic serialDataLineIn,
  input wire logic serialDataLineOeN
);
  import i2c_timing_pkg::*;
  localparam int BOTH = 0, DLO = 1, CHI = 2, CLO = 3, REL = 4, DRV = 5, DST = 6, UP = 7;
  // Runs are counted on the raw pins; the design sees them later, so these are lower bounds.
  int cnt_ff [8];
  int nxt_cnt [8];
  logic dPrev_ff;
  logic [7:0] run;
  assign run = {1'b1, serialDataLineOeN == dPrev_ff, !serialClockOeN, serialClockOeN,
    !serialClockIn, serialClockIn, serialClockIn & !serialDataLineIn,
    serialClockIn & serialDataLineIn};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_cnt[i] = run[i] ? cnt_ff[i] + 1 : 0;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '{default: 0};
      dPrev_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      dPrev_ff <= serialDataLineOeN;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_startDrive;
    $fell(serialDataLineOeN) && serialClockOeN;
  endsequence
  sequence s_clkDrive;
    $fell(serialClockOeN) && serialClockIn;
  endsequence
  sequence s_clkRelease;
    $rose(serialClockOeN);
  endsequence
  property p_startSetup; s_startDrive |-> cnt_ff[BOTH] >= CYC_SU_STA; endproperty
  a_startSetup: assert property (p_startSetup) else $error("start setup short");
  property p_startHold; s_clkDrive and !serialDataLineIn |-> cnt_ff[DLO] >= CYC_HD_STA; endproperty
  a_startHold: assert property (p_startHold) else $error("start hold short");
  property p_stopSetup;
    $rose(serialDataLineOeN) && serialClockOeN && serialClockIn |-> cnt_ff[CHI] >= CYC_SU_STO;
  endproperty
  a_stopSetup: assert property (p_stopSetup) else $error("stop setup short");
  property p_minHigh; s_clkDrive |-> cnt_ff[CHI] >= CYC_HIGH_MIN; endproperty
  a_minHigh: assert property (p_minHigh) else $error("high below minimum");
  property p_nomHigh; s_clkDrive |-> cnt_ff[REL] >= CYC_HIGH_NOM; endproperty
  a_nomHigh: assert property (p_nomHigh) else $error("high below nominal");
  property p_minLow; s_clkRelease |-> cnt_ff[CLO] >= CYC_LOW_MIN; endproperty
  a_minLow: assert property (p_minLow) else $error("low below minimum");
  property p_nomLow; s_clkRelease |-> cnt_ff[DRV] >= CYC_LOW_NOM; endproperty
  a_nomLow: assert property (p_nomLow) else $error("low below nominal");
  property p_dataSetup; s_clkRelease |-> cnt_ff[DST] >= CYC_SU_DAT; endproperty
  a_dataSetup: assert property (p_dataSetup) else $error("data setup short");
  property p_dataHold;
    $changed(serialDataLineOeN) && !serialClockOeN |-> cnt_ff[CLO] >= CYC_HD_DAT;
  endproperty
  a_dataHold: assert property (p_dataHold) else $error("data hold short");
  property p_idleFirst; s_startDrive |-> cnt_ff[UP] >= IDLE_CYC; endproperty
  a_idleFirst: assert property (p_idleFirst) else $error("start before idle detect");
endmodule : i2c_bus_timing_checker
bind i2c_bus_timing i2c_bus_timing_checker #(.IDLE_CYC(IDLE_CYC)) chk (.sys_clk(sys_clk),
  .reset(reset), .serialClockIn(serialClockIn), .serialClockOeN(serialClockOeN),
  .serialDataLineIn(serialDataLineIn), .serialDataLineOeN(serialDataLineOeN));
`default_nettype wire

// ---- sim/i2c_far_device.sv ----
// Far-side bus device that stretches the clock low phase and pulls either line on command.
`timescale 1ns/10ps
`default_nettype none
module i2c_far_device (
  input wire logic sys_clk,
  input wire logic sclLine,
  input wire logic [15:0] stretch,
  input wire logic pullClk,
  input wire logic pullData,
  output var logic clkLow,
  output var logic dataLow
);
  int hold_ff;
  int nxt_hold;
  logic sclSeen_ff;
  always_comb begin
    nxt_hold = hold_ff > 0 ? hold_ff - 1 : 0;
    if (sclSeen_ff && !sclLine && stretch > 0) nxt_hold = int'(stretch);
  end
  always_ff @(posedge sys_clk) begin
    hold_ff <= nxt_hold;
    sclSeen_ff <= sclLine;
  end
  // Both lines have pull-ups, so a line reads back high once neither side pulls it low.
  assign clkLow = pullClk || hold_ff > 0;
  assign dataLow = pullData;
endmodule : i2c_far_device
`default_nettype wire

// ---- sim/tb_i2c_bus_timing.sv ----
// Register bus and pin level bench for the two-wire bus timing block.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_bus_timing;
  import i2c_timing_pkg::*;
  localparam logic [15:0] SIM_IDLE = 16'h0028;
  localparam logic [31:0] DFLT [NUM_TIM] = '{{CYC_HD_STA, CYC_SU_STA}, {SIM_IDLE, CYC_SU_STO},
    {CYC_HD_DAT, CYC_SU_DAT}, {CYC_HIGH_NOM, CYC_LOW_NOM}, {CYC_HIGH_MIN, CYC_LOW_MIN}};
  logic sys_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, sclOut, sclOeN, sdaOut, sdaOeN, pullClk, pullData, clkLow, dataLow;
  logic [7:0] awaddr, araddr;
  logic [15:0] stretch;
  logic [31:0] wdata, rdata, v, maskVal;
  logic [1:0] bresp, rresp, r;
  int errTotal, checks, hiRun, hiLen;
  wire logic sclLine = (sclOeN | sclOut) & !clkLow;
  wire logic sdaLine = (sdaOeN | sdaOut) & !dataLow;
  i2c_bus_timing #(.IDLE_CYC(SIM_IDLE)) dut (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .serialClockIn(sclLine), .serialClockOut(sclOut),
    .serialClockOeN(sclOeN), .serialDataLineIn(sdaLine), .serialDataLineOut(sdaOut),
    .serialDataLineOeN(sdaOeN), .irq(irq));
  i2c_far_device far (.sys_clk(sys_clk), .sclLine(sclLine), .stretch(stretch),
    .pullClk(pullClk), .pullData(pullData), .clkLow(clkLow), .dataLow(dataLow));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Length of the last released-clock phase, from release to the next drive low.
  always @(posedge sys_clk) begin
    if (sclOeN) hiRun++;
    else if (hiRun > 0) begin
      hiLen = hiRun;
      hiRun = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic hung();
    errTotal++;
    $display("ERROR wait expected answer seen timeout");
    end_sim();
  endtask : hung
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    if (n == 100) hung();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    if (n == 100) hung();
  endtask : rd
  // Polls the sticky events, checks the interrupt against the mask, then clears them.
  task automatic waitEv(input int b);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(OFS_INT_STAT);
      if (v[b]) break;
    end
    if (n == 3000) hung();
    repeat (2) @(posedge sys_clk);
    check("irq", {31'h0, irq}, {31'h0, |(v & maskVal)});
    wr(OFS_INT_STAT, v);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : waitEv
  task automatic pulseClk(input int d);
    int n;
    for (n = 0; n < 5000 && sclLine !== 1'b1; n++) @(posedge sys_clk);
    if (n == 5000) hung();
    repeat (d) @(posedge sys_clk);
    pullClk <= 1'b1;
    repeat (5) @(posedge sys_clk);
    pullClk <= 1'b0;
  endtask : pulseClk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, arvalid, pullClk, pullData} = '0;
    {bready, rready, reset} = '1;
    {awaddr, araddr, wdata, maskVal, stretch} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < NUM_TIM; i++) begin
      rd(OFS_TIM0 + 8'(i) * TIM_STRIDE);
      check("timing word", v, DFLT[i]);
    end
    rd(8'h40);
    check("unmapped data", v, 32'h0);
    check("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'hffffffff);
    check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_INT_MASK, 32'h1);
    maskVal = 32'h1;
    rd(OFS_INT_MASK);
    check("mask", v, 32'h1);
    waitEv(EV_IDLE);
    rd(OFS_STATUS);
    check("bus idle", {31'h0, v[ST_IDLE]}, 32'h1);
    pullData <= 1'b1;
    repeat (10) @(posedge sys_clk);
    pullClk <= 1'b1;
    wr(OFS_CMD, 32'h1);
    repeat (100) @(posedge sys_clk);
    pullData <= 1'b0;
    repeat (10) @(posedge sys_clk);
    pullClk <= 1'b0;
    waitEv(EV_DONE);
    check("pin levels", {30'h0, sclOut, sdaOut}, 32'h0);
    wr(OFS_CMD, 32'h12);
    waitEv(EV_DONE);
    wr(OFS_TIM0 + 8'(TI_NOM) * TIM_STRIDE, {16'h0384, CYC_LOW_NOM});
    wr(OFS_CMD, 32'h2);
    waitEv(EV_DONE);
    check("high length", {31'h0, hiLen < 900}, 32'h1);
    wr(OFS_CMD, 32'h100);
    wr(OFS_CMD, 32'h12);
    waitEv(EV_DONE);
    check("high length", {31'h0, hiLen >= 900}, 32'h1);
    stretch <= 16'h05dc;
    wr(OFS_CMD, 32'h12);
    waitEv(EV_DONE);
    stretch <= 16'h0;
    wr(OFS_CMD, 32'h2);
    waitEv(EV_DONE);
    check("stretch faults", v & 32'h6, 32'h0);
    wr(OFS_CMD, 32'h12);
    pulseClk(100);
    waitEv(EV_DONE);
    check("early low faults", v & 32'h6, 32'h0);
    wr(OFS_CMD, 32'h3);
    waitEv(EV_DONE);
    rd(OFS_STATUS);
    check("bus idle", {31'h0, v[ST_IDLE]}, 32'h1);
    wr(OFS_CMD, 32'h1);
    waitEv(EV_DONE);
    wr(OFS_CMD, 32'h3);
    pulseClk(50);
    waitEv(EV_COL);
    repeat (600) @(posedge sys_clk);
    wr(OFS_SRST, 32'h1);
    wr(OFS_CMD, 32'h1);
    pulseClk(200);
    waitEv(EV_COL);
    end_sim();
  end
endmodule : tb_i2c_bus_timing
`default_nettype wire
